// >>> hdl/sdadc_regs.sv
`timescale 1ns/1ps
`default_nettype none

module sdadc_regs
  import sdadc_pkg::*;
#(
  parameter int CLK_DIV = CONV_CLK_DIV
) (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic result_valid,
  input wire logic [RESULT_W-1:0] result_data,
  output sdadc_ctrl_t analog_ctrl,
  output logic converter_clock,
  output logic decimation_strobe,
  output logic filter_reset,
  output logic conversion_irq
);

  // ==========================================================
  // decode helpers
  // ==========================================================
  function automatic logic is_mapped(input logic [5:0] idx);
    case (idx)
      IDX_INTERRUPT_ENABLE_0, IDX_INTERRUPT_FLAG_0, IDX_RL_H, IDX_RL_M, IDX_RL_L,
      IDX_RR_H, IDX_RR_M, IDX_RR_L, IDX_PWR0, IDX_PWR1,
      IDX_CCN0, IDX_CCN1, IDX_CCN2: is_mapped = 1'b1;
      default: is_mapped = 1'b0;
    endcase
  endfunction

  function automatic logic [14:0] osr_len(input logic [2:0] code);
    osr_len = OSR_MIN << (3'h7 - code);
  endfunction

  // ==========================================================
  // state
  // ==========================================================
  logic [7:0] interrupt_enable_0_ff;
  logic flag_ff;
  logic [7:0] pwr0_ff;
  logic [7:0] pwr1_ff;
  logic [7:0] ccn0_ff;
  logic [7:0] ccn1_ff;
  logic [7:0] ccn2_ff;
  logic [RESULT_W-1:0] result_ff;

  logic aw_held_ff;
  logic w_held_ff;
  logic [5:0] waddr_ff;
  logic [7:0] wdata_ff;
  logic wlane_ff;
  logic awready_ff;
  logic wready_ff;
  logic bvalid_ff;
  logic [1:0] bresp_ff;
  logic arready_ff;
  logic rvalid_ff;
  logic [31:0] rdata_ff;
  logic [1:0] rresp_ff;

  logic [15:0] div_cnt_ff;
  logic conv_tick_ff;
  logic [14:0] osr_cnt_ff;
  logic strobe_ff;
  logic filt_rst_ff;
  logic irq_ff;
  sdadc_ctrl_t ctrl_ff;

  logic wr_fire;
  logic wr_ok;
  logic [5:0] rd_idx;
  logic [7:0] rd_byte;

  // ==========================================================
  // write channel: address and data taken in either order
  // ==========================================================
  assign wr_fire = aw_held_ff && w_held_ff && !bvalid_ff;
  assign wr_ok = wr_fire && is_mapped(waddr_ff) && wlane_ff;

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      aw_held_ff <= 1'b0;
      awready_ff <= 1'b0;
      waddr_ff <= 6'h00;
    end else if (s_axi_awvalid && awready_ff) begin
      aw_held_ff <= 1'b1;
      awready_ff <= 1'b0;
      waddr_ff <= s_axi_awaddr[7:2];
    end else if (wr_fire) begin
      aw_held_ff <= 1'b0;
    end else begin
      awready_ff <= !aw_held_ff && !bvalid_ff;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      w_held_ff <= 1'b0;
      wready_ff <= 1'b0;
      wdata_ff <= 8'h00;
      wlane_ff <= 1'b0;
    end else if (s_axi_wvalid && wready_ff) begin
      w_held_ff <= 1'b1;
      wready_ff <= 1'b0;
      wdata_ff <= s_axi_wdata[7:0];
      wlane_ff <= s_axi_wstrb[0];
    end else if (wr_fire) begin
      w_held_ff <= 1'b0;
    end else begin
      wready_ff <= !w_held_ff && !bvalid_ff;
    end
  end

  // unmapped index answers slverr; a write without lane 0 is a no-op
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      bvalid_ff <= 1'b0;
      bresp_ff <= RESP_OKAY;
    end else if (wr_fire) begin
      bvalid_ff <= 1'b1;
      bresp_ff <= is_mapped(waddr_ff) ? RESP_OKAY : RESP_SLVERR;
    end else if (s_axi_bready) begin
      bvalid_ff <= 1'b0;
    end
  end

  // ==========================================================
  // control registers
  // ==========================================================
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      interrupt_enable_0_ff <= REG_RESET;
      pwr0_ff <= REG_RESET;
      pwr1_ff <= REG_RESET;
      ccn0_ff <= REG_RESET;
      ccn1_ff <= REG_RESET;
      ccn2_ff <= REG_RESET;
    end else if (wr_ok) begin
      case (waddr_ff)
        IDX_INTERRUPT_ENABLE_0: interrupt_enable_0_ff <= wdata_ff;
        IDX_PWR0: pwr0_ff <= wdata_ff;
        IDX_PWR1: pwr1_ff <= wdata_ff;
        IDX_CCN0: ccn0_ff <= wdata_ff;
        IDX_CCN1: ccn1_ff <= wdata_ff;
        // reset bit is an action, it never stays set
        IDX_CCN2: ccn2_ff <= {wdata_ff[7:1], 1'b0};
        default: ;
      endcase
    end
  end

  // flag: hardware set beats a software clear in the same cycle
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      flag_ff <= 1'b0;
    end else if (result_valid && pwr0_ff[BIT_CONV_EN]) begin
      flag_ff <= 1'b1;
    end else if (wr_ok && waddr_ff == IDX_INTERRUPT_FLAG_0 &&
                 !wdata_ff[BIT_CONV_IF]) begin
      flag_ff <= 1'b0;
    end
  end

  // one capture feeds both views so no view mixes two conversions
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      result_ff <= '0;
    end else if (result_valid && pwr0_ff[BIT_CONV_EN]) begin
      result_ff <= result_data;
    end
  end

  // ==========================================================
  // read channel
  // ==========================================================
  assign rd_idx = s_axi_araddr[7:2];

  always_comb begin
    case (rd_idx)
      IDX_INTERRUPT_ENABLE_0: rd_byte = interrupt_enable_0_ff;
      IDX_INTERRUPT_FLAG_0: rd_byte = {1'b0, flag_ff, 6'h00};
      IDX_RL_H: rd_byte = result_ff[19:12];
      IDX_RL_M: rd_byte = result_ff[11:4];
      IDX_RL_L: rd_byte = {result_ff[3:0], 4'h0};
      IDX_RR_H: rd_byte = {{4{result_ff[19]}}, result_ff[19:16]};
      IDX_RR_M: rd_byte = result_ff[15:8];
      IDX_RR_L: rd_byte = result_ff[7:0];
      IDX_PWR0: rd_byte = pwr0_ff;
      IDX_PWR1: rd_byte = pwr1_ff;
      IDX_CCN0: rd_byte = ccn0_ff;
      IDX_CCN1: rd_byte = ccn1_ff;
      IDX_CCN2: rd_byte = ccn2_ff;
      default: rd_byte = 8'h00;
    endcase
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      arready_ff <= 1'b0;
      rvalid_ff <= 1'b0;
      rdata_ff <= 32'h0000_0000;
      rresp_ff <= RESP_OKAY;
    end else if (s_axi_arvalid && arready_ff) begin
      arready_ff <= 1'b0;
      rvalid_ff <= 1'b1;
      rdata_ff <= {24'h00_0000, rd_byte};
      rresp_ff <= is_mapped(rd_idx) ? RESP_OKAY : RESP_SLVERR;
    end else if (rvalid_ff) begin
      rvalid_ff <= !s_axi_rready;
    end else begin
      arready_ff <= 1'b1;
    end
  end

  // ==========================================================
  // converter clock enable and oversampling period
  // ==========================================================
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      div_cnt_ff <= 16'h0000;
      conv_tick_ff <= 1'b0;
    end else if (div_cnt_ff == 16'(CLK_DIV - 1)) begin
      div_cnt_ff <= 16'h0000;
      conv_tick_ff <= 1'b1;
    end else begin
      div_cnt_ff <= div_cnt_ff + 16'h0001;
      conv_tick_ff <= 1'b0;
    end
  end

  // period restarts on filter reset or while the converter is off
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      osr_cnt_ff <= 15'h0000;
      strobe_ff <= 1'b0;
    end else if (filt_rst_ff || !pwr0_ff[BIT_CONV_EN]) begin
      osr_cnt_ff <= 15'h0000;
      strobe_ff <= 1'b0;
    end else if (conv_tick_ff) begin
      if (osr_cnt_ff >= osr_len(ccn0_ff[7:5]) - 15'h0001) begin
        osr_cnt_ff <= 15'h0000;
        strobe_ff <= 1'b1;
      end else begin
        osr_cnt_ff <= osr_cnt_ff + 15'h0001;
        strobe_ff <= 1'b0;
      end
    end else begin
      strobe_ff <= 1'b0;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      filt_rst_ff <= 1'b0;
    end else begin
      filt_rst_ff <= wr_ok && waddr_ff == IDX_CCN2 &&
                     wdata_ff[BIT_FILTER_RST];
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      irq_ff <= 1'b0;
    end else begin
      irq_ff <= flag_ff && interrupt_enable_0_ff[BIT_CONV_IE] &&
                interrupt_enable_0_ff[BIT_GIE];
    end
  end

  // ==========================================================
  // analog control outputs
  // ==========================================================
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      ctrl_ff <= '0;
    end else begin
      ctrl_ff.bandgap_enable <= pwr0_ff[BIT_BANDGAP];
      // sensor power follows only its own bit, never the converter enable
      ctrl_ff.temp_sensor_enable <= pwr0_ff[BIT_TEMP_EN];
      ctrl_ff.input_short_select <= pwr0_ff[BIT_SHORT];
      ctrl_ff.sensor_polarity_reverse <= pwr0_ff[BIT_POLARITY];
      ctrl_ff.converter_enable <= pwr0_ff[BIT_CONV_EN];
      ctrl_ff.power_control_1 <= pwr1_ff;
      ctrl_ff.decimation_ratio_select <= ccn0_ff[7:5];
      ctrl_ff.reference_halving <= ccn0_ff[4];
      ctrl_ff.input_gain_select <= ccn0_ff[3:2];
      ctrl_ff.analog_ground_select <= ccn0_ff[1:0];
      ctrl_ff.negative_input_select <= ccn1_ff[7:5];
      ctrl_ff.positive_input_select <= ccn1_ff[4:2];
      ctrl_ff.reference_input_select <= ccn1_ff[1:0];
      ctrl_ff.dc_bias_select <= ccn2_ff[7:5];
      ctrl_ff.ref_resistor_select <= ccn2_ff[4:3];
    end
  end

  assign s_axi_awready = awready_ff;
  assign s_axi_wready = wready_ff;
  assign s_axi_bvalid = bvalid_ff;
  assign s_axi_bresp = bresp_ff;
  assign s_axi_arready = arready_ff;
  assign s_axi_rvalid = rvalid_ff;
  assign s_axi_rdata = rdata_ff;
  assign s_axi_rresp = rresp_ff;
  assign analog_ctrl = ctrl_ff;
  assign converter_clock = conv_tick_ff;
  assign decimation_strobe = strobe_ff;
  assign filter_reset = filt_rst_ff;
  assign conversion_irq = irq_ff;

endmodule

`default_nettype wire

// >>> hdl/sdadc_pkg.sv
package sdadc_pkg;

  // ==========================================================
  // register indices (byte address is four times the index)
  // ==========================================================
  localparam logic [5:0] IDX_INTERRUPT_ENABLE_0 = 6'h23;
  localparam logic [5:0] IDX_INTERRUPT_FLAG_0 = 6'h26;
  localparam logic [5:0] IDX_RL_H = 6'h2D;
  localparam logic [5:0] IDX_RL_M = 6'h2E;
  localparam logic [5:0] IDX_RL_L = 6'h2F;
  localparam logic [5:0] IDX_RR_H = 6'h30;
  localparam logic [5:0] IDX_RR_M = 6'h31;
  localparam logic [5:0] IDX_RR_L = 6'h32;
  localparam logic [5:0] IDX_PWR0 = 6'h33;
  localparam logic [5:0] IDX_PWR1 = 6'h34;
  localparam logic [5:0] IDX_CCN0 = 6'h35;
  localparam logic [5:0] IDX_CCN1 = 6'h36;
  localparam logic [5:0] IDX_CCN2 = 6'h37;

  // ==========================================================
  // field positions and reset values
  // ==========================================================
  localparam int BIT_GIE = 7;
  localparam int BIT_CONV_IE = 6;
  localparam int BIT_CONV_IF = 6;
  localparam int BIT_BANDGAP = 7;
  localparam int BIT_TEMP_EN = 6;
  localparam int BIT_SHORT = 4;
  localparam int BIT_POLARITY = 3;
  localparam int BIT_CONV_EN = 0;
  localparam int BIT_FILTER_RST = 0;
  localparam logic [7:0] REG_RESET = 8'h00;

  localparam int RESULT_W = 20;
  localparam logic [14:0] OSR_MIN = 15'h0080;

  // ==========================================================
  // timing: converter clock derived from the system clock
  // ==========================================================
  localparam int SYS_CLK_MHZ = 250;
  localparam int CONV_CLK_PERIOD_NS = 1000;
  localparam int CONV_CLK_DIV = CONV_CLK_PERIOD_NS * SYS_CLK_MHZ / 1000;

  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // ==========================================================
  // analog control bundle
  // ==========================================================
  typedef struct packed {
    logic bandgap_enable;
    logic temp_sensor_enable;
    logic input_short_select;
    logic sensor_polarity_reverse;
    logic converter_enable;
    logic [7:0] power_control_1;
    logic [2:0] decimation_ratio_select;
    logic reference_halving;
    logic [1:0] input_gain_select;
    logic [1:0] analog_ground_select;
    logic [2:0] negative_input_select;
    logic [2:0] positive_input_select;
    logic [1:0] reference_input_select;
    logic [2:0] dc_bias_select;
    logic [1:0] ref_resistor_select;
  } sdadc_ctrl_t;

endpackage

// >>> sim/sdadc_regs_asserts.sv
`timescale 1ns/1ps
`default_nettype none
module sdadc_regs_asserts
  import sdadc_pkg::*;
#(
  parameter int CLK_DIV = 4
) (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire sdadc_ctrl_t analog_ctrl,
  input wire logic converter_clock,
  input wire logic decimation_strobe,
  input wire logic filter_reset
);
  // ==========================================================
  // helper counters
  // ==========================================================
  int div_ff;
  int tick_ff;
  logic seen_ff;
  logic run_ff;
  logic hold;
  assign hold = !analog_ctrl.converter_enable || filter_reset;
  always_ff @(posedge sys_clk) begin
    if (rst || converter_clock) div_ff <= 0;
    else div_ff <= div_ff + 1;
  end
  always_ff @(posedge sys_clk) begin
    if (rst) seen_ff <= 1'b0;
    else if (converter_clock) seen_ff <= 1'b1;
  end
  // first period after enable is skipped: its start phase is design choice
  always_ff @(posedge sys_clk) begin
    if (rst || hold) run_ff <= 1'b0;
    else if (decimation_strobe) run_ff <= 1'b1;
  end
  always_ff @(posedge sys_clk) begin
    if (rst || hold || decimation_strobe) tick_ff <= 0;
    else if (converter_clock) tick_ff <= tick_ff + 1;
  end
  // ==========================================================
  // properties
  // ==========================================================
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);
  clk_period_a: assert property (converter_clock && seen_ff |->
    div_ff == CLK_DIV - 1) else $error("converter tick spacing wrong");
  // the strobe is registered off the tick, so it trails the tick by a cycle
  decim_tick_a: assert property (decimation_strobe |->
    $past(converter_clock) && analog_ctrl.converter_enable)
    else $error("strobe without tick or enable");
  decim_period_a: assert property (decimation_strobe && run_ff |->
    tick_ff == (128 << (7 - analog_ctrl.decimation_ratio_select)))
    else $error("oversampling period wrong");
  frst_pulse_a: assert property (filter_reset |=> !filter_reset)
    else $error("filter reset longer than one cycle");
  frst_write_a: assert property (filter_reset |->
    $rose(s_axi_bvalid)) else $error("filter reset not tied to write");
  b_done_a: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
    else $error("write response repeated");
  r_done_a: assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid)
    else $error("read response repeated");
  r_byte_a: assert property (s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h000000)
    else $error("read data upper bits set");
  reset_clear_a: assert property (@(posedge sys_clk) disable iff (1'b0)
    rst |=> !s_axi_bvalid && !s_axi_rvalid && analog_ctrl == '0)
    else $error("state not cleared by reset");
endmodule
bind sdadc_regs sdadc_regs_asserts #(.CLK_DIV(CLK_DIV)) sdadc_regs_asserts_i (
  .sys_clk(sys_clk), .rst(rst), .s_axi_bresp(s_axi_bresp),
  .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
  .s_axi_rdata(s_axi_rdata), .s_axi_rvalid(s_axi_rvalid),
  .s_axi_rready(s_axi_rready), .analog_ctrl(analog_ctrl),
  .converter_clock(converter_clock), .decimation_strobe(decimation_strobe),
  .filter_reset(filter_reset));
`default_nettype wire

// >>> sim/sdadc_mod_model.sv
`timescale 1ns/1ps
`default_nettype none
module sdadc_mod_model (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic decimation_strobe,
  input wire logic filter_reset,
  input wire logic inject,
  input wire logic [1:0] lag,
  input wire logic [19:0] sample,
  output logic result_valid,
  output logic [19:0] result_data
);
  // ==========================================================
  // comb filter output, lag + 2 cycles after each period-end strobe
  // ==========================================================
  logic pend_ff;
  logic [1:0] cnt_ff;
  logic fire;
  assign fire = (pend_ff && cnt_ff == 2'h0) || inject;
  always_ff @(posedge sys_clk) begin
    if (rst || filter_reset) begin
      pend_ff <= 1'b0;
      cnt_ff <= 2'h0;
    end else if (decimation_strobe) begin
      pend_ff <= 1'b1;
      cnt_ff <= lag;
    end else if (fire) begin
      pend_ff <= 1'b0;
    end else if (pend_ff) begin
      cnt_ff <= cnt_ff - 2'h1;
    end
  end
  always_ff @(posedge sys_clk) begin
    result_valid <= fire && !rst;
  end
  // data off the strobe is inverted so a stale value never looks valid
  always_ff @(posedge sys_clk) begin
    result_data <= fire ? sample : ~result_data;
  end
endmodule
`default_nettype wire

// >>> sim/tb_sdadc_regs.sv
`timescale 1ns/1ps
`default_nettype none
module tb_sdadc_regs;
  import sdadc_pkg::*;
  localparam int DIV = 4;
  logic sys_clk = 1'b0;
  logic rst = 1'b1;
  logic [7:0] awaddr = '0, araddr = '0;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
  logic arvalid = 1'b0, rready = 1'b0, inject = 1'b0;
  logic [31:0] wdata = '0;
  logic [3:0] wstrb = '0;
  logic [1:0] lag = '0;
  logic [19:0] sample = '0;
  logic awready, wready, bvalid, arready, rvalid, rvld, conv_clk, strobe;
  logic frst, irq, saw_frst = 1'b0;
  logic [1:0] bresp, rresp;
  logic [31:0] rdata;
  logic [19:0] rdat;
  sdadc_ctrl_t ctrl;
  int n_errors = 0, checks = 0, cyc = 0, t_last = 0, t_prev = 0;
  // row: index, write byte, expected read byte, expected response
  logic [31:0] rows [10] = '{32'h23C0C000, 32'h26FF0000,
    32'h34A5A500, 32'h35E5E500, 32'h36FCFC00, 32'h37E1E000,
    32'h2D550000, 32'h32AA0000, 32'h24FF0002, 32'h33484800};
  int pb [5] = '{7, 6, 4, 3, 0};
  always #2 sys_clk = ~sys_clk;
  always @(posedge sys_clk) begin
    cyc <= cyc + 1;
    if (frst === 1'b1) saw_frst <= 1'b1;
    if (rvld === 1'b1) begin
      t_prev <= t_last;
      t_last <= cyc;
    end
  end
  sdadc_regs #(.CLK_DIV(DIV)) sdadc_regs_i (.sys_clk(sys_clk), .rst(rst),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
    .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
    .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
    .s_axi_rvalid(rvalid), .s_axi_rready(rready), .result_valid(rvld),
    .result_data(rdat), .analog_ctrl(ctrl), .converter_clock(conv_clk),
    .decimation_strobe(strobe), .filter_reset(frst), .conversion_irq(irq));
  sdadc_mod_model sdadc_mod_model_i (.sys_clk(sys_clk), .rst(rst),
    .decimation_strobe(strobe), .filter_reset(frst), .inject(inject),
    .lag(lag), .sample(sample), .result_valid(rvld), .result_data(rdat));
  // ==========================================================
  // tasks
  // ==========================================================
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      n_errors++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic end_sim();
    $display("checks %0d mismatches %0d", checks, n_errors);
    if (n_errors == 0 && checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  task automatic wait_hi(ref logic s);
    int n;
    n = 0;
    while (s !== 1'b1 && n < 3000) begin
      @(posedge sys_clk);
      n++;
    end
    if (n >= 3000) begin
      n_errors++;
      end_sim();
    end
  endtask
  task automatic wr(input logic [5:0] idx, input logic [7:0] d,
    output logic [1:0] r);
    @(posedge sys_clk);
    awaddr <= {idx, 2'b00};
    wdata <= {24'h000000, d};
    wstrb <= 4'hF;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge sys_clk);
      if (awready === 1'b1) awvalid <= 1'b0;
      if (wready === 1'b1) wvalid <= 1'b0;
    end while (bvalid !== 1'b1 && cyc < 90000);
    if (cyc >= 90000) begin
      n_errors++;
      end_sim();
    end
    r = bresp;
    bready <= 1'b0;
  endtask
  task automatic rchk(input logic [5:0] idx, input logic [7:0] exp);
    @(posedge sys_clk);
    araddr <= {idx, 2'b00};
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge sys_clk);
      if (arready === 1'b1) arvalid <= 1'b0;
    end while (rvalid !== 1'b1 && cyc < 90000);
    if (cyc >= 90000) begin
      n_errors++;
      end_sim();
    end
    chk(rdata, {24'h000000, exp});
    rready <= 1'b0;
  endtask
  // ==========================================================
  // main sequence
  // ==========================================================
  initial begin
    logic [1:0] r;
    logic [2:0] k;
    logic [19:0] d;
    repeat (3) @(posedge sys_clk);
    rst <= 1'b0;
    foreach (rows[i]) begin
      wr(rows[i][29:24], rows[i][23:16], r);
      chk(r, rows[i][1:0]);
      rchk(rows[i][29:24], rows[i][15:8]);
    end
    chk(saw_frst, 1'b1);
    rchk(IDX_PWR0, 8'h48);
    chk(rresp, RESP_OKAY);
    rchk(6'h24, 8'h00);
    chk(rresp, RESP_SLVERR);
    $display("register table test done");
    @(posedge sys_clk);
    rst <= 1'b1;
    repeat (3) @(posedge sys_clk);
    rst <= 1'b0;
    foreach (rows[i]) rchk(rows[i][29:24], 8'h00);
    $display("mid-run reset test done");
    for (int j = 0; j < 8; j++) begin
      k = j[2:0];
      wr(IDX_CCN0, {k, k[0], k[1:0], ~k[1:0]}, r);
      wr(IDX_CCN1, {k, ~k, k[1:0]}, r);
      wr(IDX_CCN2, {k, 5'h00}, r);
      @(negedge sys_clk);
      chk({ctrl.decimation_ratio_select, ctrl.reference_halving,
        ctrl.input_gain_select, ctrl.analog_ground_select},
        {k, k[0], k[1:0], ~k[1:0]});
      chk({ctrl.negative_input_select, ctrl.positive_input_select},
        {k, ~k});
      chk(ctrl.dc_bias_select, k);
    end
    $display("control field test done");
    for (int j = 0; j < 5; j++) begin
      wr(IDX_PWR0, 8'h01 << pb[j], r);
      @(negedge sys_clk);
      chk({ctrl.bandgap_enable, ctrl.temp_sensor_enable,
        ctrl.input_short_select, ctrl.sensor_polarity_reverse,
        ctrl.converter_enable}, 5'h10 >> j);
    end
    $display("power control test done");
    lag <= 2'h1;
    wr(IDX_CCN0, 8'hEC, r);
    wr(IDX_INTERRUPT_ENABLE_0, 8'hC0, r);
    for (int s = 0; s < 2; s++) begin
      d = (s == 0) ? 20'hA5C3E : 20'h31234;
      sample <= d;
      wr(IDX_CCN1, (s == 0) ? 8'hF8 : 8'hD8, r);
      wr(IDX_PWR0, (s == 0) ? 8'h49 : 8'h41, r);
      // drop a flag left by a result taken before this sample was set
      wr(IDX_INTERRUPT_FLAG_0, 8'h00, r);
      wait_hi(irq);
      rchk(IDX_RL_H, d[19:12]);
      rchk(IDX_RL_M, d[11:4]);
      rchk(IDX_RL_L, {d[3:0], 4'h0});
      rchk(IDX_RR_H, {{4{d[19]}}, d[19:16]});
      rchk(IDX_RR_M, d[15:8]);
      rchk(IDX_RR_L, d[7:0]);
      rchk(IDX_INTERRUPT_FLAG_0, 8'h40);
      wr(IDX_INTERRUPT_FLAG_0, 8'h00, r);
    end
    chk(t_last - t_prev, 128 * DIV);
    $display("conversion test done");
    wr(IDX_INTERRUPT_ENABLE_0, 8'h40, r);
    wait_hi(rvld);
    repeat (3) @(posedge sys_clk);
    chk(irq, 1'b0);
    rchk(IDX_INTERRUPT_FLAG_0, 8'h40);
    wr(IDX_INTERRUPT_FLAG_0, 8'h00, r);
    wr(IDX_PWR0, 8'h00, r);
    sample <= 20'h0F0F0;
    inject <= 1'b1;
    @(posedge sys_clk);
    inject <= 1'b0;
    repeat (3) @(posedge sys_clk);
    rchk(IDX_INTERRUPT_FLAG_0, 8'h00);
    rchk(IDX_RR_L, 8'h34);
    $display("mask and disabled test done");
    end_sim();
  end
endmodule
`default_nettype wire
